// *** acsc_regs.svh ***
`ifndef ACSC_REGS_SVH
`define ACSC_REGS_SVH

// ----------------------------------------
// command codes
// ----------------------------------------
`define ACSC_CMD_RESUME0  8'h00
`define ACSC_CMD_RESUME1  8'hFF
`define ACSC_CMD_ALIGN    8'hFC
`define ACSC_CMD_RESET    8'hFE
`define ACSC_CMD_GAINCAL  8'hF4
`define ACSC_CMD_STANDBY  8'hFD
`define ACSC_CMD_RDCONT   8'h03
`define ACSC_CMD_SDCONT   8'h0F
// ----------------------------------------
// register defaults and fields
// ----------------------------------------
`define ACSC_CTRL_RST     8'h20
`define ACSC_CTRL_CLK_LO  5
`define ACSC_CTRL_CLK_HI  6
`define ACSC_FSC_RST      24'h400000
// ----------------------------------------
// timing
// ----------------------------------------
`define ACSC_CLK_NS       8
`define ACSC_SCLK_HALF_NS 80
`define ACSC_SCLK_HALF_CYC ((`ACSC_SCLK_HALF_NS + `ACSC_CLK_NS - 1) / `ACSC_CLK_NS)
`define ACSC_CAL_NS       2000
`define ACSC_CAL_CYC      ((`ACSC_CAL_NS + `ACSC_CLK_NS - 1) / `ACSC_CLK_NS)
`define ACSC_CONV_MCLK    8'h20
`define ACSC_RDY_LOW_MCLK 8'h04
`endif

// *** acsc_pkg.sv ***
package acsc_pkg;
  typedef enum logic [1:0] {
    DEV_RUN  = 2'b00,
    DEV_CAL  = 2'b01,
    DEV_STBY = 2'b10,
    DEV_HALT = 2'b11
  } acsc_dev_st_e;
  typedef enum logic [2:0] {
    HST_IDLE  = 3'b000,
    HST_SETUP = 3'b001,
    HST_HIGH  = 3'b010,
    HST_LOW   = 3'b011,
    HST_GAP   = 3'b100,
    HST_WAIT  = 3'b101
  } acsc_host_st_e;
endpackage : acsc_pkg

// *** acsc_if.sv ***
interface acsc_if;
  logic sclk;
  logic cs_n;
  logic din;
  logic data_ready_n;
  modport dev (
    input  sclk,
    input  cs_n,
    input  din,
    output data_ready_n
  );
  modport host (
    output sclk,
    output cs_n,
    output din,
    input  data_ready_n
  );
endinterface : acsc_if

// *** acsc_sync3.sv ***
// three-stage pin synchroniser; output moves once stages two and three agree
module acsc_sync3 (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic d_i,
  output logic      q_o
);
  logic s1_q, s2_q, s3_q, out_q;
  logic out_d;

  // first stage feeds only the second
  always_comb begin
    out_d = (s2_q == s3_q) ? s3_q : out_q;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s1_q  <= 1'b0;
      s2_q  <= 1'b0;
      s3_q  <= 1'b0;
      out_q <= 1'b0;
    end else begin
      s1_q  <= d_i;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      out_q <= out_d;
    end
  end

  assign q_o = out_q;
endmodule : acsc_sync3

// *** acsc_dev.sv ***
`include "acsc_regs.svh"
// device end: command shifter, calibration, align, standby, register reset
module acsc_dev (
  input  wire logic     clk_i,
  input  wire logic     rst_n_i,
  acsc_if.dev           link,
  input  wire logic     master_clock_in_i,
  input  wire logic [23:0] gain_meas_i,
  input  wire logic     ctrl_load_i,
  input  wire logic [7:0] ctrl_val_i,
  output logic [7:0]    converter_control_o,
  output logic [23:0]   full_scale_cal_o,
  output logic          continuous_read_mode_o,
  output logic          standby_o,
  output logic          conv_sync_o,
  output logic          cmd_valid_o,
  output logic [7:0]    cmd_byte_o
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic sclk_s, cs_n_s, din_s, mclk_s;

  acsc_sync3 u_sclk (.clk_i(clk_i), .rst_n_i(rst_n_i), .d_i(link.sclk), .q_o(sclk_s));
  acsc_sync3 u_cs   (.clk_i(clk_i), .rst_n_i(rst_n_i), .d_i(link.cs_n), .q_o(cs_n_s));
  acsc_sync3 u_din  (.clk_i(clk_i), .rst_n_i(rst_n_i), .d_i(link.din), .q_o(din_s));
  acsc_sync3 u_mclk (.clk_i(clk_i), .rst_n_i(rst_n_i), .d_i(master_clock_in_i),
                     .q_o(mclk_s));

  // ----------------------------------------
  // state
  // ----------------------------------------
  acsc_pkg::acsc_dev_st_e st_q, st_d;
  logic        sclk_p_q, sclk_p_d;
  logic        mclk_p_q, mclk_p_d;
  logic [2:0]  bit_q, bit_d;
  logic [6:0]  sh_q, sh_d;
  logic        arm_q, arm_d;
  logic        pend_q, pend_d;
  logic [7:0]  cal_q, cal_d;
  logic [7:0]  conv_q, conv_d;
  logic        rdy_n_q, rdy_n_d;
  logic [7:0]  ctrl_q, ctrl_d;
  logic [23:0] fsc_q, fsc_d;
  logic        rdc_q, rdc_d;
  logic        sync_q, sync_d;
  logic        cv_q, cv_d;
  logic [7:0]  cb_q, cb_d;
  logic        stby_q, stby_d;

  logic       sclk_rise, mclk_rise, byte_done;
  logic [7:0] byte_w;
  logic [7:0] keep_mask;

  // resume has two legal codes, both handled alike
  function automatic logic is_resume(input logic [7:0] b);
    is_resume = (b == `ACSC_CMD_RESUME0) || (b == `ACSC_CMD_RESUME1);
  endfunction : is_resume

  // edges count only while select is low, so standby ignores a busy bus otherwise
  assign sclk_rise = sclk_s & ~sclk_p_q & ~cs_n_s;
  assign mclk_rise = mclk_s & ~mclk_p_q;
  assign byte_w    = {sh_q, din_s};
  assign byte_done = sclk_rise && (bit_q == 3'h7);
  assign keep_mask = 8'h00 | (8'h01 << `ACSC_CTRL_CLK_LO) | (8'h01 << `ACSC_CTRL_CLK_HI);

  // ----------------------------------------
  // next-state logic
  // ----------------------------------------
  always_comb begin
    st_d     = st_q;
    sclk_p_d = sclk_s;
    mclk_p_d = mclk_s;
    bit_d    = bit_q;
    sh_d     = sh_q;
    arm_d    = arm_q;
    pend_d   = pend_q;
    cal_d    = cal_q;
    conv_d   = conv_q;
    rdy_n_d  = rdy_n_q;
    ctrl_d   = ctrl_load_i ? ctrl_val_i : ctrl_q;
    fsc_d    = fsc_q;
    rdc_d    = rdc_q;
    sync_d   = 1'b0;
    cv_d     = 1'b0;
    cb_d     = cb_q;

    // byte assembly, msb first; select high restarts the count
    if (cs_n_s) begin
      bit_d = 3'h0;
    end else if (sclk_rise) begin
      bit_d = bit_q + 3'h1;
      sh_d  = {sh_q[5:0], din_s};
    end

    // the resume byte's first clock arms the align
    if (pend_q && sclk_rise && (bit_q == 3'h0)) begin
      arm_d  = 1'b1;
      pend_d = 1'b0;
    end

    // free-running conversions paced by the master clock
    if (st_q == acsc_pkg::DEV_RUN && mclk_rise) begin
      if (conv_q == `ACSC_CONV_MCLK - 8'h01) begin
        conv_d  = 8'h00;
        rdy_n_d = 1'b0;
      end else begin
        conv_d = conv_q + 8'h01;
        if (conv_q == `ACSC_RDY_LOW_MCLK - 8'h01) begin
          rdy_n_d = 1'b1;
        end
      end
    end

    unique case (st_q)
      acsc_pkg::DEV_RUN: ;
      acsc_pkg::DEV_CAL: begin
        // new gain result lands only once the calibration time has run
        if (cal_q == 8'h00) begin
          fsc_d   = gain_meas_i;
          rdy_n_d = 1'b0;
          conv_d  = 8'h00;
          st_d    = acsc_pkg::DEV_RUN;
        end else begin
          cal_d = cal_q - 8'h01;
        end
      end
      acsc_pkg::DEV_STBY: begin
        // any clock with select low breaks standby
        if (sclk_rise) begin
          st_d   = acsc_pkg::DEV_RUN;
          conv_d = 8'h00;
        end
      end
      acsc_pkg::DEV_HALT: begin
        // conversions restart on the first master clock rising edge after arming
        if (arm_q && mclk_rise) begin
          sync_d  = 1'b1;
          arm_d   = 1'b0;
          conv_d  = 8'h00;
          rdy_n_d = 1'b1;
          st_d    = acsc_pkg::DEV_RUN;
        end
      end
    endcase

    // command decode on the eighth bit; calibration refuses new bytes
    if (byte_done && st_q != acsc_pkg::DEV_CAL) begin
      cv_d = 1'b1;
      cb_d = byte_w;
      if (byte_w == `ACSC_CMD_GAINCAL) begin
        st_d    = acsc_pkg::DEV_CAL;
        cal_d   = 8'(`ACSC_CAL_CYC);
        rdy_n_d = 1'b1;
        arm_d   = 1'b0;
        pend_d  = 1'b0;
      end else if (byte_w == `ACSC_CMD_ALIGN) begin
        st_d   = acsc_pkg::DEV_HALT;
        pend_d = 1'b1;
        arm_d  = 1'b0;
      end else if (byte_w == `ACSC_CMD_STANDBY) begin
        // rest here until a clock with select low brings back free-running conversions
        st_d = acsc_pkg::DEV_STBY;
      end else if (is_resume(byte_w)) begin
        if (st_q == acsc_pkg::DEV_STBY) begin
          st_d   = acsc_pkg::DEV_RUN;
          conv_d = 8'h00;
        end
      end else if (byte_w == `ACSC_CMD_RESET) begin
        // clock-out rate bits survive so the host clock is not disturbed
        ctrl_d = (ctrl_q & keep_mask) | (`ACSC_CTRL_RST & ~keep_mask);
        fsc_d  = `ACSC_FSC_RST;
        rdc_d  = 1'b0;
      end else if (byte_w == `ACSC_CMD_RDCONT) begin
        rdc_d = 1'b1;
      end else if (byte_w == `ACSC_CMD_SDCONT) begin
        rdc_d = 1'b0;
      end
    end

    // standby flag kept in its own flop so the output has no decode behind it
    stby_d = (st_d == acsc_pkg::DEV_STBY);
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_q     <= acsc_pkg::DEV_RUN;
      sclk_p_q <= 1'b0;
      mclk_p_q <= 1'b0;
      bit_q    <= 3'h0;
      sh_q     <= 7'h00;
      arm_q    <= 1'b0;
      pend_q   <= 1'b0;
      cal_q    <= 8'h00;
      conv_q   <= 8'h00;
      rdy_n_q  <= 1'b1;
      ctrl_q   <= `ACSC_CTRL_RST;
      fsc_q    <= `ACSC_FSC_RST;
      rdc_q    <= 1'b0;
      sync_q   <= 1'b0;
      cv_q     <= 1'b0;
      cb_q     <= 8'h00;
      stby_q   <= 1'b0;
    end else begin
      st_q     <= st_d;
      sclk_p_q <= sclk_p_d;
      mclk_p_q <= mclk_p_d;
      bit_q    <= bit_d;
      sh_q     <= sh_d;
      arm_q    <= arm_d;
      pend_q   <= pend_d;
      cal_q    <= cal_d;
      conv_q   <= conv_d;
      rdy_n_q  <= rdy_n_d;
      ctrl_q   <= ctrl_d;
      fsc_q    <= fsc_d;
      rdc_q    <= rdc_d;
      sync_q   <= sync_d;
      cv_q     <= cv_d;
      cb_q     <= cb_d;
      stby_q   <= stby_d;
    end
  end

  assign link.data_ready_n      = rdy_n_q;
  assign converter_control_o    = ctrl_q;
  assign full_scale_cal_o       = fsc_q;
  assign continuous_read_mode_o = rdc_q;
  assign standby_o              = stby_q;
  assign conv_sync_o            = sync_q;
  assign cmd_valid_o            = cv_q;
  assign cmd_byte_o             = cb_q;
endmodule : acsc_dev

// *** acsc_host.sv ***
`include "acsc_regs.svh"
// host end: serial master that shifts single command bytes
module acsc_host (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  acsc_if.host            link,
  input  wire logic       cmd_valid_i,
  input  wire logic [7:0] cmd_byte_i,
  output logic            cmd_ready_o,
  output logic            data_ready_n_o
);
  logic rdy_n_s;

  acsc_sync3 u_rdy (.clk_i(clk_i), .rst_n_i(rst_n_i), .d_i(link.data_ready_n),
                    .q_o(rdy_n_s));

  acsc_pkg::acsc_host_st_e st_q, st_d;
  logic [7:0] tm_q, tm_d;
  logic [2:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d;
  logic       sclk_q, sclk_d;
  logic       cs_n_q, cs_n_d;
  logic       din_q, din_d;
  logic       rdc_q, rdc_d;
  logic       chain_q, chain_d;
  logic       gcal_q, gcal_d;
  logic       rdy_q, rdy_d;
  logic       rdn_q;
  logic       need_wait;

  localparam logic [7:0] HALF = 8'(`ACSC_SCLK_HALF_CYC - 1);

  // reset in continuous mode must wait for data ready low
  assign need_wait = (cmd_byte_i == `ACSC_CMD_RESET) && rdc_q && rdy_n_s;

  // ----------------------------------------
  // next-state logic
  // ----------------------------------------
  always_comb begin
    st_d    = st_q;
    tm_d    = (tm_q == 8'h00) ? 8'h00 : tm_q - 8'h01;
    bit_d   = bit_q;
    sh_d    = sh_q;
    sclk_d  = sclk_q;
    cs_n_d  = cs_n_q;
    din_d   = din_q;
    rdc_d   = rdc_q;
    chain_d = chain_q;
    gcal_d  = gcal_q;
    rdy_d   = 1'b0;
    unique case (st_q)
      acsc_pkg::HST_IDLE: begin
        rdy_d = ~need_wait;
        if (chain_q) begin
          // align is always followed by resume
          sh_d    = `ACSC_CMD_RESUME0;
          chain_d = 1'b0;
          cs_n_d  = 1'b0;
          din_d   = 1'b0;
          tm_d    = HALF;
          bit_d   = 3'h0;
          rdy_d   = 1'b0;
          st_d    = acsc_pkg::HST_SETUP;
        end else if (cmd_valid_i && rdy_q && !need_wait) begin
          // ready was computed against last cycle's byte, so the wait is checked again here
          sh_d    = cmd_byte_i;
          chain_d = (cmd_byte_i == `ACSC_CMD_ALIGN);
          // the shifter is emptied by the end of the byte, so remember the command
          gcal_d  = (cmd_byte_i == `ACSC_CMD_GAINCAL);
          if (cmd_byte_i == `ACSC_CMD_RDCONT) begin
            rdc_d = 1'b1;
          end else if (cmd_byte_i == `ACSC_CMD_SDCONT || cmd_byte_i == `ACSC_CMD_RESET) begin
            rdc_d = 1'b0;
          end
          cs_n_d = 1'b0;
          din_d  = cmd_byte_i[7];
          tm_d   = HALF;
          bit_d  = 3'h0;
          rdy_d  = 1'b0;
          st_d   = acsc_pkg::HST_SETUP;
        end
      end
      acsc_pkg::HST_SETUP, acsc_pkg::HST_LOW: begin
        if (tm_q == 8'h00) begin
          sclk_d = 1'b1;
          tm_d   = HALF;
          st_d   = acsc_pkg::HST_HIGH;
        end
      end
      acsc_pkg::HST_HIGH: begin
        // data changes on the falling edge, msb first
        if (tm_q == 8'h00) begin
          sclk_d = 1'b0;
          tm_d   = HALF;
          if (bit_q == 3'h7) begin
            st_d = acsc_pkg::HST_GAP;
          end else begin
            bit_d = bit_q + 3'h1;
            sh_d  = {sh_q[6:0], 1'b0};
            din_d = sh_q[6];
            st_d  = acsc_pkg::HST_LOW;
          end
        end
      end
      acsc_pkg::HST_GAP: begin
        // select rises only after the clock has fallen, so standby stays quiet
        if (tm_q == 8'h00) begin
          cs_n_d = 1'b1;
          din_d  = 1'b0;
          tm_d   = HALF;
          st_d   = acsc_pkg::HST_WAIT;
        end
      end
      acsc_pkg::HST_WAIT: begin
        // after gain calibration hold off until data ready falls
        if (tm_q == 8'h00 && (!gcal_q || !rdy_n_s)) begin
          st_d = acsc_pkg::HST_IDLE;
        end
      end
      default: st_d = acsc_pkg::HST_IDLE;
    endcase
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_q    <= acsc_pkg::HST_IDLE;
      tm_q    <= 8'h00;
      bit_q   <= 3'h0;
      sh_q    <= 8'h00;
      sclk_q  <= 1'b0;
      cs_n_q  <= 1'b1;
      din_q   <= 1'b0;
      rdc_q   <= 1'b0;
      chain_q <= 1'b0;
      gcal_q  <= 1'b0;
      rdy_q   <= 1'b0;
      rdn_q   <= 1'b1;
    end else begin
      st_q    <= st_d;
      tm_q    <= tm_d;
      bit_q   <= bit_d;
      sh_q    <= sh_d;
      sclk_q  <= sclk_d;
      cs_n_q  <= cs_n_d;
      din_q   <= din_d;
      rdc_q   <= rdc_d;
      chain_q <= chain_d;
      gcal_q  <= gcal_d;
      rdy_q   <= rdy_d;
      rdn_q   <= rdy_n_s;
    end
  end

  assign link.sclk      = sclk_q;
  assign link.cs_n      = cs_n_q;
  assign link.din       = din_q;
  assign cmd_ready_o    = rdy_q;
  assign data_ready_n_o = rdn_q;
endmodule : acsc_host

// *** acsc_chk.sv ***
// wire-level checks between the two ends; only interface signals are seen
module acsc_chk (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  input wire logic data_ready_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       sclk_q;
  logic       dr_q;
  logic       wait_q;
  logic       wait_d;
  logic [2:0] nbit_q;
  logic [2:0] nbit_d;
  logic [7:0] sh_q;
  logic [7:0] sh_d;
  logic       rise;
  logic       f4_done;
  // ----------------------------------------
  // byte tracker
  // ----------------------------------------
  // rebuilds each byte off the wire so calibration timing can be judged
  always_comb begin
    rise    = sclk & ~sclk_q;
    f4_done = rise && (nbit_q == 3'h7) && ({sh_q[6:0], din} == 8'hF4);
    nbit_d  = cs_n ? 3'h0 : nbit_q + {2'h0, rise};
    sh_d    = rise ? {sh_q[6:0], din} : sh_q;
    // the wait ends on a fall of data ready, not its level, which may start low
    wait_d  = f4_done | (wait_q & ~(dr_q & ~data_ready_n));
  end
  // registers only
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sclk_q <= 1'b0;
      dr_q   <= 1'b1;
      wait_q <= 1'b0;
      nbit_q <= 3'h0;
      sh_q   <= 8'h00;
    end else begin
      sclk_q <= sclk;
      dr_q   <= data_ready_n;
      wait_q <= wait_d;
      nbit_q <= nbit_d;
      sh_q   <= sh_d;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_idle; cs_n |-> !sclk; endproperty
  a_idle: assert property (p_idle) else $error("serial clock active while deselected");
  property p_setup; $fell(cs_n) |-> !sclk [*8]; endproperty
  a_setup: assert property (p_setup) else $error("serial clock too soon after select");
  property p_half; $rose(sclk) |-> sclk [*8] ##2 sclk ##1 !sclk; endproperty
  a_half: assert property (p_half) else $error("serial clock high half not ten cycles");
  property p_din; sclk && $past(sclk) |-> $stable(din); endproperty
  a_din: assert property (p_din) else $error("data in moved while clock high");
  property p_frame; $rose(cs_n) |-> nbit_q == 3'h0; endproperty
  a_frame: assert property (p_frame) else $error("frame not whole bytes");
  property p_cal_hi; f4_done |-> ##12 data_ready_n [*8]; endproperty
  a_cal_hi: assert property (p_cal_hi) else $error("data ready not high in calibration");
  property p_cal_lo; f4_done |-> ##[240:270] !data_ready_n; endproperty
  a_cal_lo: assert property (p_cal_lo) else $error("calibration end not flagged");
  property p_hold; wait_q |-> !$fell(cs_n); endproperty
  a_hold: assert property (p_hold) else $error("command sent during calibration");
endmodule : acsc_chk

// *** tb_adc_serial_command_control.sv ***
`include "acsc_regs.svh"
module tb_adc_serial_command_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i     = 1'b0;
  logic        rst_n_i   = 1'b0;
  logic        mclk      = 1'b0;
  logic        cmd_valid = 1'b0;
  logic [7:0]  cmd_byte  = 8'h00;
  logic        ctrl_load = 1'b0;
  logic [7:0]  ctrl_val  = 8'h00;
  logic [23:0] gain      = 24'h123456;
  logic        cs_q      = 1'b1;
  logic [7:0]  ctrl;
  logic [23:0] full_scale_cal_reg;
  logic        cont;
  logic        stby;
  logic        sync;
  logic        ready;
  logic [7:0]  cbyte;
  logic        cv;
  logic        rdn;
  int          bad_count = 0;
  int          checks    = 0;
  int          frames    = 0;
  int          sync_at   = 0;
  int          accepted  = 0;
  int          f0;
  acsc_if link ();
  acsc_dev acsc_dev_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .link(link),
    .master_clock_in_i(mclk), .gain_meas_i(gain), .ctrl_load_i(ctrl_load),
    .ctrl_val_i(ctrl_val), .converter_control_o(ctrl), .full_scale_cal_o(full_scale_cal_reg),
    .continuous_read_mode_o(cont), .standby_o(stby), .conv_sync_o(sync),
    .cmd_valid_o(cv), .cmd_byte_o(cbyte));
  acsc_host acsc_host_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .link(link),
    .cmd_valid_i(cmd_valid), .cmd_byte_i(cmd_byte), .cmd_ready_o(ready),
    .data_ready_n_o(rdn));
  acsc_chk acsc_chk_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .sclk(link.sclk),
    .cs_n(link.cs_n), .din(link.din), .data_ready_n(link.data_ready_n));
  // ----------------------------------------
  // clocks
  // ----------------------------------------
  initial begin
    forever #4 clk_i = ~clk_i;
  end
  // master clock offset so its edges never line up with the system clock
  initial begin
    #3;
    forever #80 mclk = ~mclk;
  end
  // frame counter; records in which frame the align pulse landed
  always @(posedge clk_i) begin
    cs_q <= link.cs_n;
    if (cs_q && !link.cs_n) frames <= frames + 1;
    if (sync === 1'b1) sync_at <= frames;
    if (cv === 1'b1) accepted <= accepted + 1;
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic final_report();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // polls ready at falling edges, so a value seen here holds at the next rise
  task automatic wait_ready();
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 3000) begin
      @(negedge clk_i);
      n++;
    end
    if (n >= 3000) begin
      bad_count++;
      final_report();
    end
  endtask : wait_ready
  // offer a byte, hold it until the frame starts, then wait until the host is idle again;
  // dropping valid once select falls keeps a lingering request from being taken twice
  task automatic send(input logic [7:0] b, input logic [7:0] last);
    int n;
    n = 0;
    @(negedge clk_i);
    wait_ready();
    cmd_byte  = b;
    cmd_valid = 1'b1;
    @(negedge clk_i);
    while (link.cs_n !== 1'b0 && n < 3000) begin
      @(negedge clk_i);
      n++;
    end
    cmd_valid = 1'b0;
    if (n >= 3000) begin
      bad_count++;
      final_report();
    end
    wait_ready();
    chk({16'h0000, cbyte}, {16'h0000, last});
  endtask : send
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(negedge clk_i);
    rst_n_i = 1'b1;
    @(negedge clk_i);
    chk({16'h0000, ctrl}, {16'h0000, `ACSC_CTRL_RST});
    chk(full_scale_cal_reg, `ACSC_FSC_RST);
    chk({23'h000000, cont}, 24'h000000);
    $display("test reset done");
    send(`ACSC_CMD_GAINCAL, `ACSC_CMD_GAINCAL);
    chk(full_scale_cal_reg, gain);
    chk({23'h000000, link.data_ready_n}, 24'h000000);
    chk({23'h000000, rdn}, 24'h000000);
    $display("test calibration done");
    // both resume codes, each after its own standby
    for (int i = 0; i < 2; i++) begin
      send(`ACSC_CMD_STANDBY, `ACSC_CMD_STANDBY);
      chk({23'h000000, stby}, 24'h000001);
      send(i ? `ACSC_CMD_RESUME1 : `ACSC_CMD_RESUME0, i ? 8'hFF : 8'h00);
      chk({23'h000000, stby}, 24'h000000);
    end
    $display("test standby done");
    f0 = frames;
    send(`ACSC_CMD_ALIGN, `ACSC_CMD_RESUME0);
    chk(sync_at[23:0], f0[23:0] + 24'h000002);
    $display("test align done");
    send(`ACSC_CMD_RDCONT, `ACSC_CMD_RDCONT);
    chk({23'h000000, cont}, 24'h000001);
    ctrl_val  = 8'hFF;
    ctrl_load = 1'b1;
    @(negedge clk_i);
    ctrl_load = 1'b0;
    // reset keeps only the clock-out rate bits of the loaded value
    send(`ACSC_CMD_RESET, `ACSC_CMD_RESET);
    chk({23'h000000, cont}, 24'h000000);
    chk({16'h0000, ctrl}, {16'h0000, (`ACSC_CTRL_RST & 8'h9F) | 8'h60});
    chk(full_scale_cal_reg, `ACSC_FSC_RST);
    send(`ACSC_CMD_RDCONT, `ACSC_CMD_RDCONT);
    send(`ACSC_CMD_SDCONT, `ACSC_CMD_SDCONT);
    chk({23'h000000, cont}, 24'h000000);
    chk(accepted[23:0], 24'h00000B);
    $display("test reset command done");
    final_report();
  end
endmodule : tb_adc_serial_command_control
